// File: core/tac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - Any of the four non-maskable events sets the nmi seen flag.
// RULE2 - Flag clears only by writing 0 after reading 1; writing 1 ignored.
// RULE3 - While the flag is 1 no new activation is started.
// RULE4 - A flag rising mid-transfer lets the running transfer finish.
// RULE5 - Software waits 16 or 128 clocks after watchdog before clearing.
// RULE6 - Software disables oscillation-stop interrupt before clearing flag.
// RULE7 - Each activation reads control data, transfers, writes it back.
// RULE8 - Twenty-four independent control data sets are supported.
// RULE9 - Normal and repeat modes are selected per control data set.
// RULE10 - Chain bit set makes the next set run in the same activation.
// RULE11 - 16-bit addresses each held or incremented per set.
// RULE12 - Only sources with their activation enable bit set activate.
// RULE13 - Count reaching 0 on first transfer clears the source enable. Code keeps the enable in repeat mode when CCR_REPEAT_IRQ_ENABLE is 0.
// RULE14 - Otherwise timer match or flash ready source flag gets cleared.
// RULE15 - Simultaneous requests are served one at a time by priority.
// RULE16 - At completion the highest priority pending request goes next.
// RULE17 - Activation ignores the CPU interrupt mask and controls.
// RULE18 - Enabled sources do not set their interrupt request flag.
// RULE19 - Unassigned control bits read 0; software writes 0 there.
// RULE20 - Count 00h means 256; count decrements once per activation.
// RULE21 - Repeat mode reloads the count from the reload byte.
// RULE22 - Requests during an operation are held pending, never lost. Code drops requests that arrive while the nmi flag is set.
module tac_top #(
	parameter int CD_SETS = tac_pkg::CD_SETS
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_reset_n,
	input  wire logic [15:0]                   i_addr,
	input  wire logic [7:0]                    i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic [7:0]                         o_rdata,
	input  wire logic [tac_pkg::NMI_SRCS-1:0]  i_nmi_event,
	input  wire logic [tac_pkg::SRC_NUM-1:0]   i_src_req,
	output var tac_pkg::tac_mem_req_t          o_mem,
	input  wire logic [7:0]                    i_mem_rdata,
	output var tac_pkg::tac_flag_clr_t         o_flag_clr,
	output logic [tac_pkg::SRC_NUM-1:0]        o_ir_suppress,
	output logic                               o_busy
);

	localparam int IW = $clog2(tac_pkg::SRC_NUM);

	logic [7:0]                  en_q [tac_pkg::EN_REGS];
	logic [7:0]                  en_d [tac_pkg::EN_REGS];
	logic [tac_pkg::SRC_NUM-1:0] en_flat;
	logic [tac_pkg::SRC_NUM-1:0] pend_q;
	logic [tac_pkg::SRC_NUM-1:0] pend_d;
	logic [tac_pkg::EN_REGS-1:0] en_hit;
	logic                        nmi_q, nmi_d;
	logic                        read1_q, read1_d;
	logic                        rsv_q, rsv_d;
	logic [7:0]                  rd_q, rd_d;
	tac_pkg::tac_state_t         st_q, st_d, ret_q, ret_d;
	logic [IW-1:0]               src_q, src_d, top_idx;
	logic                        found, take, en_kill;
	logic [4:0]                  set_q, set_d;
	logic [2:0]                  bidx_q, bidx_d;
	logic [7:0]                  cd_q [tac_pkg::CD_BYTES];
	logic [7:0]                  cd_d [tac_pkg::CD_BYTES];
	logic [7:0]                  dat_q, dat_d, cct_new;
	logic [8:0]                  cnt_q, cnt_d;
	logic                        first_q, first_d, busy_q, busy_d;
	logic                        act_wr, act_rd, rpt, last_beat;
	tac_pkg::tac_mem_req_t       mem_q, mem_d;
	tac_pkg::tac_flag_clr_t      clr_q, clr_d;

	// ***************************************************
	// Register decode
	// ***************************************************
	function automatic logic [tac_pkg::EN_REGS-1:0] en_sel(
		input logic [15:0] a);
		en_sel = '0;
		for (int i = 0; i < tac_pkg::EN_REGS; i++) begin
			if (i != tac_pkg::EN_GAP &&
			    a == tac_pkg::EN_BASE_ADDR + 16'(i)) begin
				en_sel[i] = 1'b1;
			end
		end
	endfunction

	// Strobes qualified by address
	assign act_wr    = i_wr && (i_addr == tac_pkg::ACT_CTRL_ADDR);
	assign act_rd    = i_rd && (i_addr == tac_pkg::ACT_CTRL_ADDR);
	assign en_hit    = en_sel(i_addr);
	assign rpt       = cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_RPT];
	assign cct_new   = cd_q[tac_pkg::CD_CCT] - 8'h01;
	assign last_beat = (st_q == tac_pkg::S_DST_WR) && (cnt_q == 9'h001);
	assign take      = (st_q == tac_pkg::S_IDLE) && found && !nmi_q;

	// ***************************************************
	// Activation enables and pending requests
	// ***************************************************
	always_comb begin
		for (int i = 0; i < tac_pkg::EN_REGS; i++) begin
			en_flat[i*8 +: 8] = en_q[i];
		end
	end

	// Enable bytes: software writes, hardware end-of-count clear
	always_comb begin
		en_d = en_q;
		for (int i = 0; i < tac_pkg::EN_REGS; i++) begin
			if (i_wr && en_hit[i]) begin
				en_d[i] = i_wdata;
			end
		end
		if (en_kill) begin
			en_d[src_q[IW-1:3]][src_q[2:0]] = 1'b0; // RULE13
		end
	end

	// Pending set wins over the clear of the taken one
	always_comb begin
		pend_d = pend_q;
		if (take) begin
			pend_d[top_idx] = 1'b0; // RULE15
		end
		if (!nmi_q) begin
			pend_d = pend_d | (i_src_req & en_flat); // RULE12 RULE22
		end
		pend_d = pend_d & en_flat;
	end

	tac_prio_enc #(
		.N       (tac_pkg::SRC_NUM)
	) u_prio (
		.i_req   (pend_q),
		.o_found (found),
		.o_idx   (top_idx)
	);

	// ***************************************************
	// Activation control register
	// ***************************************************
	always_comb begin
		nmi_d   = nmi_q;
		read1_d = read1_q;
		rsv_d   = rsv_q;
		if (act_rd) begin
			read1_d = nmi_q;
		end
		if (act_wr) begin
			rsv_d   = i_wdata[tac_pkg::RSV_BIT];
			read1_d = 1'b0;
			if (!i_wdata[tac_pkg::NMI_BIT] && read1_q) begin
				nmi_d = 1'b0; // RULE2
			end
		end
		if (|i_nmi_event) begin
			nmi_d = 1'b1; // RULE1
		end
	end

	// Read data, unmapped reads as zero
	always_comb begin
		rd_d = 8'h00;
		if (act_rd) begin
			rd_d[tac_pkg::NMI_BIT] = nmi_q; // RULE19
			rd_d[tac_pkg::RSV_BIT] = rsv_q;
		end
		for (int i = 0; i < tac_pkg::EN_REGS; i++) begin
			if (i_rd && en_hit[i]) begin
				rd_d = en_q[i];
			end
		end
	end

	// ***************************************************
	// Transfer sequencer
	// ***************************************************
	always_comb begin
		st_d    = st_q;
		ret_d   = ret_q;
		src_d   = src_q;
		set_d   = set_q;
		bidx_d  = bidx_q;
		cd_d    = cd_q;
		dat_d   = dat_q;
		cnt_d   = cnt_q;
		first_d = first_q;
		busy_d  = busy_q;
		mem_d   = '0;
		clr_d   = '0;
		en_kill = 1'b0;
		unique case (st_q)
			tac_pkg::S_IDLE: begin
				busy_d = 1'b0;
				// Mask flag and interrupt controls are not consulted
				if (take) begin // RULE3 RULE16 RULE17
					src_d   = top_idx;
					first_d = 1'b1;
					busy_d  = 1'b1;
					mem_d   = tac_pkg::mem_rd(tac_pkg::VEC_BASE_ADDR +
						16'(top_idx));
					ret_d   = tac_pkg::S_VEC_CAP;
					st_d    = tac_pkg::S_WAIT;
				end
			end
			tac_pkg::S_WAIT: begin
				st_d = ret_q;
			end
			tac_pkg::S_VEC_CAP: begin
				set_d  = i_mem_rdata[4:0];
				bidx_d = 3'h0;
				st_d   = tac_pkg::S_CD_RD;
			end
			tac_pkg::S_CD_RD: begin
				mem_d = tac_pkg::mem_rd(tac_pkg::cd_addr(set_q, bidx_q));
				ret_d = tac_pkg::S_CD_CAP;
				st_d  = tac_pkg::S_WAIT;
			end
			tac_pkg::S_CD_CAP: begin
				cd_d[bidx_q] = i_mem_rdata; // RULE7
				bidx_d       = bidx_q + 3'h1;
				st_d         = tac_pkg::S_CD_RD;
				if (bidx_q == tac_pkg::CD_DAH) begin
					cnt_d = (cd_q[tac_pkg::CD_BLS] == 8'h00) ?
						tac_pkg::BLK_FULL : {1'b0, cd_q[tac_pkg::CD_BLS]};
					st_d  = tac_pkg::S_SRC_RD;
				end
			end
			tac_pkg::S_SRC_RD: begin
				mem_d = tac_pkg::mem_rd({cd_q[tac_pkg::CD_SAH],
					cd_q[tac_pkg::CD_SAL]});
				ret_d = tac_pkg::S_SRC_CAP;
				st_d  = tac_pkg::S_WAIT;
			end
			tac_pkg::S_SRC_CAP: begin
				dat_d = i_mem_rdata;
				st_d  = tac_pkg::S_DST_WR;
			end
			tac_pkg::S_DST_WR: begin
				mem_d = tac_pkg::mem_wr({cd_q[tac_pkg::CD_DAH],
					cd_q[tac_pkg::CD_DAL]}, dat_q);
				// Address steps, each on its own enable
				if (cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_SINC]) begin
					{cd_d[tac_pkg::CD_SAH], cd_d[tac_pkg::CD_SAL]} =
						{cd_q[tac_pkg::CD_SAH], cd_q[tac_pkg::CD_SAL]} +
						16'h0001; // RULE11
				end
				if (cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_DINC]) begin
					{cd_d[tac_pkg::CD_DAH], cd_d[tac_pkg::CD_DAL]} =
						{cd_q[tac_pkg::CD_DAH], cd_q[tac_pkg::CD_DAL]} +
						16'h0001; // RULE11
				end
				cnt_d = cnt_q - 9'h001;
				st_d  = tac_pkg::S_SRC_RD;
				if (last_beat) begin
					// 00h wraps to FFh, giving 256 activations
					cd_d[tac_pkg::CD_CCT] = cct_new; // RULE20
					if (cct_new == 8'h00 && rpt) begin
						cd_d[tac_pkg::CD_CCT] =
							cd_q[tac_pkg::CD_RLD]; // RULE9 RULE21
					end
					if (first_q) begin
						if (cct_new == 8'h00 && (!rpt ||
						    cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_REPEAT_IRQ_ENABLE])) begin
							en_kill = 1'b1; // RULE13
						end else begin
							clr_d = tac_pkg::flag_for(src_q); // RULE14
						end
					end
					bidx_d = 3'h0;
					st_d   = tac_pkg::S_WB;
				end
			end
			tac_pkg::S_WB: begin
				mem_d  = tac_pkg::mem_wr(tac_pkg::cd_addr(set_q, bidx_q),
					cd_q[bidx_q]); // RULE7
				bidx_d = bidx_q + 3'h1;
				if (bidx_q == tac_pkg::CD_DAH) begin
					if (cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_CHAIN_ENABLE]) begin
						first_d = 1'b0; // RULE10
						st_d    = tac_pkg::S_CD_RD;
						set_d   = (set_q == 5'(CD_SETS - 1)) ? 5'h00 :
							set_q + 5'h01; // RULE8
					end else begin
						busy_d = 1'b0;
						st_d   = tac_pkg::S_IDLE;
					end
				end
			end
			default: begin
				busy_d = 1'b0;
				st_d   = tac_pkg::S_IDLE;
			end
		endcase
	end

	// ***************************************************
	// State registers
	// ***************************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_q    <= '{default: 8'h00};
			pend_q  <= '0;
			nmi_q   <= 1'b0;
			read1_q <= 1'b0;
			rsv_q   <= 1'b0;
			rd_q    <= 8'h00;
			st_q    <= tac_pkg::S_IDLE;
			ret_q   <= tac_pkg::S_IDLE;
			src_q   <= '0;
			set_q   <= 5'h00;
			bidx_q  <= 3'h0;
			cd_q    <= '{default: 8'h00};
			dat_q   <= 8'h00;
			cnt_q   <= 9'h000;
			first_q <= 1'b0;
			busy_q  <= 1'b0;
			mem_q   <= '0;
			clr_q   <= '0;
		end else begin
			en_q    <= en_d;
			pend_q  <= pend_d;
			nmi_q   <= nmi_d;
			read1_q <= read1_d;
			rsv_q   <= rsv_d;
			rd_q    <= rd_d;
			st_q    <= st_d;
			ret_q   <= ret_d;
			src_q   <= src_d;
			set_q   <= set_d;
			bidx_q  <= bidx_d;
			cd_q    <= cd_d;
			dat_q   <= dat_d;
			cnt_q   <= cnt_d;
			first_q <= first_d;
			busy_q  <= busy_d;
			mem_q   <= mem_d;
			clr_q   <= clr_d;
		end
	end

	// Outputs straight from flops
	assign o_rdata       = rd_q;
	assign o_mem         = mem_q;
	assign o_flag_clr    = clr_q;
	assign o_busy        = busy_q;
	assign o_ir_suppress = en_flat; // RULE18

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_cd_fetch;
		st_q == tac_pkg::S_CD_RD ##1 st_q == tac_pkg::S_WAIT
			##1 st_q == tac_pkg::S_CD_CAP;
	endsequence

	property p_nmi_set;
		|i_nmi_event |=> nmi_q;
	endproperty
	a_nmi_set: assert property (p_nmi_set) // RULE1
		else $error("nmi flag not set by event");

	property p_nmi_clr;
		$fell(nmi_q) |-> $past(act_wr && !i_wdata[tac_pkg::NMI_BIT]
			&& read1_q);
	endproperty
	a_nmi_clr: assert property (p_nmi_clr) // RULE2
		else $error("nmi flag cleared without read-one write-zero");

	property p_nmi_block;
		st_q == tac_pkg::S_IDLE && nmi_q |=> !busy_q;
	endproperty
	a_nmi_block: assert property (p_nmi_block) // RULE3
		else $error("activation started while nmi flag set");

	property p_finish;
		busy_q && st_q != tac_pkg::S_WB && st_q != tac_pkg::S_IDLE
			|=> busy_q;
	endproperty
	a_finish: assert property (p_finish) // RULE4
		else $error("transfer abandoned before write back");

	property p_fetch;
		st_q == tac_pkg::S_VEC_CAP |=> s_cd_fetch;
	endproperty
	a_fetch: assert property (p_fetch) // RULE7
		else $error("control data not fetched after vector");

	property p_chain;
		st_q == tac_pkg::S_WB && bidx_q == tac_pkg::CD_DAH &&
			cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_CHAIN_ENABLE] |=> s_cd_fetch;
	endproperty
	a_chain: assert property (p_chain) // RULE10
		else $error("chained set not fetched");

	property p_en_clear;
		last_beat && first_q && cct_new == 8'h00 && (!rpt ||
			cd_q[tac_pkg::CD_CCR][tac_pkg::CCR_REPEAT_IRQ_ENABLE])
			|=> !en_flat[src_q];
	endproperty
	a_en_clear: assert property (p_en_clear) // RULE13
		else $error("enable bit not cleared at end of count");

	property p_flag_clr;
		|o_flag_clr |-> $past(last_beat && first_q);
	endproperty
	a_flag_clr: assert property (p_flag_clr) // RULE14
		else $error("source flag cleared at wrong moment");

	property p_prio;
		take |=> src_q == $past(top_idx) && busy_q;
	endproperty
	a_prio: assert property (p_prio) // RULE16
		else $error("activation not for highest priority request");

	property p_rd_zero;
		act_rd |=> o_rdata[7:2] == 6'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) // RULE19
		else $error("unassigned control bits read nonzero");

	property p_reload;
		last_beat && rpt && cd_q[tac_pkg::CD_CCT] == 8'h01
			|=> cd_q[tac_pkg::CD_CCT] == $past(cd_q[tac_pkg::CD_RLD]);
	endproperty
	a_reload: assert property (p_reload) // RULE21
		else $error("repeat count not reloaded");

endmodule // tac_top
`default_nettype wire

// File: core/tac_pkg.sv
package tac_pkg;

	// ***************************************************
	// Register map and field positions
	// ***************************************************
	localparam logic [15:0] ACT_CTRL_ADDR = 16'h0080;
	localparam logic [15:0] EN_BASE_ADDR  = 16'h0088;
	localparam int          EN_REGS       = 7;
	localparam int          EN_GAP        = 4;  // No enable register here
	localparam int          SRC_NUM       = EN_REGS * 8;
	localparam int          NMI_SRCS      = 4;
	localparam int          NMI_BIT       = 1;
	localparam int          RSV_BIT       = 0;

	// ***************************************************
	// Control data area
	// ***************************************************
	localparam logic [15:0] VEC_BASE_ADDR = 16'h2C00;
	localparam logic [15:0] CD_BASE_ADDR  = 16'h2C40;
	localparam int          CD_BYTES      = 8;
	localparam int          CD_SETS       = 24;
	localparam logic [2:0]  CD_CCR        = 3'h0;
	localparam logic [2:0]  CD_BLS        = 3'h1;
	localparam logic [2:0]  CD_CCT        = 3'h2;
	localparam logic [2:0]  CD_RLD        = 3'h3;
	localparam logic [2:0]  CD_SAL        = 3'h4;
	localparam logic [2:0]  CD_SAH        = 3'h5;
	localparam logic [2:0]  CD_DAL        = 3'h6;
	localparam logic [2:0]  CD_DAH        = 3'h7;
	localparam logic [8:0]  BLK_FULL      = 9'h100;

	// Transfer control byte fields
	localparam int          CCR_REPEAT_IRQ_ENABLE    = 0;
	localparam int          CCR_CHAIN_ENABLE      = 1;
	localparam int          CCR_DINC      = 2;
	localparam int          CCR_SINC      = 3;
	localparam int          CCR_RPT       = 4;

	// ***************************************************
	// Sources whose peripheral flag is cleared
	// ***************************************************
	localparam logic [5:0]  SRC_MATCH_A   = 6'h11;
	localparam logic [5:0]  SRC_MATCH_B   = 6'h10;
	localparam logic [5:0]  SRC_MATCH_C   = 6'h1F;
	localparam logic [5:0]  SRC_MATCH_D   = 6'h1E;
	localparam logic [5:0]  SRC_FLASH_RDY = 6'h33;

	// Software wait after a watchdog event, in CPU clocks
	localparam int          WDT_WAIT_DIV16  = 16;
	localparam int          WDT_WAIT_DIV128 = 128;

	// ***************************************************
	// Types
	// ***************************************************
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} tac_mem_req_t;

	typedef struct packed {
		logic [3:0] match;
		logic       flash_ready;
	} tac_flag_clr_t;

	typedef enum logic [3:0] {
		S_IDLE    = 4'h0,
		S_WAIT    = 4'h1,
		S_VEC_CAP = 4'h2,
		S_CD_RD   = 4'h3,
		S_CD_CAP  = 4'h4,
		S_SRC_RD  = 4'h5,
		S_SRC_CAP = 4'h6,
		S_DST_WR  = 4'h7,
		S_WB      = 4'h8
	} tac_state_t;

	// ***************************************************
	// Helpers
	// ***************************************************
	function automatic logic [15:0] cd_addr(input logic [4:0] set,
		input logic [2:0] b);
		cd_addr = CD_BASE_ADDR + {8'h00, set, b};
	endfunction

	function automatic tac_mem_req_t mem_rd(input logic [15:0] a);
		mem_rd = '{req: 1'b1, we: 1'b0, addr: a, wdata: 8'h00};
	endfunction

	function automatic tac_mem_req_t mem_wr(input logic [15:0] a,
		input logic [7:0] d);
		mem_wr = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
	endfunction

	function automatic tac_flag_clr_t flag_for(input logic [5:0] s);
		flag_for.match[0]    = (s == SRC_MATCH_A);
		flag_for.match[1]    = (s == SRC_MATCH_B);
		flag_for.match[2]    = (s == SRC_MATCH_C);
		flag_for.match[3]    = (s == SRC_MATCH_D);
		flag_for.flash_ready = (s == SRC_FLASH_RDY);
	endfunction

endpackage

// File: core/tac_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module tac_prio_enc #(
	parameter int N = 56
) (
	input  wire logic [N-1:0]         i_req,
	output logic                      o_found,
	output logic [$clog2(N)-1:0]      o_idx
);

	// ***************************************************
	// Lowest index wins
	// ***************************************************
	always_comb begin
		o_found = 1'b0;
		o_idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_found = 1'b1;
				o_idx   = ($clog2(N))'(i);
			end
		end
	end

endmodule // tac_prio_enc
`default_nettype wire

// File: verification/tac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module tac_mem_model (
	input  wire tac_pkg::tac_mem_req_t i_mem,
	input  wire logic                  i_clk,
	output logic [7:0]                 o_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q;
	logic       valid_q;

	// ****************************
	// Storage and one-cycle read pipe
	// ****************************
	// Plain always: the bench also preloads the array directly
	always @(posedge i_clk) begin
		valid_q <= i_mem.req && !i_mem.we;
		if (i_mem.req && i_mem.we) begin
			mem[i_mem.addr] <= i_mem.wdata;
		end
		if (i_mem.req && !i_mem.we) begin
			last_q <= mem[i_mem.addr];
		end
	end

	// Data only in the answer cycle, inverse of it otherwise
	assign o_rdata = valid_q ? last_q : ~last_q;
endmodule // tac_mem_model
`default_nettype wire

// File: verification/tac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tac_top_tb;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  exp;
	} tac_row_t;

	logic                         clk;
	logic                         reset_n;
	logic [15:0]                  addr;
	logic [7:0]                   wdata;
	logic [7:0]                   rdata;
	logic                         wr;
	logic                         rd;
	logic [3:0]                   nmi;
	logic [tac_pkg::SRC_NUM-1:0]  src;
	tac_pkg::tac_mem_req_t        mem;
	logic [7:0]                   mem_rdata;
	tac_pkg::tac_flag_clr_t       flag_clr;
	logic [tac_pkg::SRC_NUM-1:0]  ir_sup;
	logic                         busy;
	int                           miscompares;
	int                           checks_done;
	int                           mem_reads;
	int                           clr_a;
	int                           n0;
	int                           t;
	logic [15:0]                  vecq [$];
	logic [7:0]                   rv;
	logic                         osc_irq_en;
	tac_row_t                     rows [9] = '{
		'{16'h0088, 8'hA5, 8'hA5}, '{16'h0089, 8'h5A, 8'h5A},
		'{16'h008A, 8'hFF, 8'hFF}, '{16'h008B, 8'h01, 8'h01},
		'{16'h008D, 8'h80, 8'h80}, '{16'h008E, 8'h7E, 8'h7E},
		'{16'h008C, 8'hFF, 8'h00}, '{16'h0087, 8'hFF, 8'h00},
		'{16'h0080, 8'h00, 8'h00}};

	tac_top dut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_nmi_event(nmi), .i_src_req(src), .o_mem(mem),
		.i_mem_rdata(mem_rdata), .o_flag_clr(flag_clr),
		.o_ir_suppress(ir_sup), .o_busy(busy));
	tac_mem_model u_mem (.i_mem(mem), .i_clk(clk), .o_rdata(mem_rdata));

	// Clock
	always #20 clk = ~clk;

	// Watch memory traffic and flag clears
	always @(posedge clk) begin
		if (mem.req && !mem.we) mem_reads++;
		if (mem.req && !mem.we && mem.addr[15:6] == 10'h0B0) begin
			vecq.push_back(mem.addr);
		end
		if (flag_clr.match[0]) clr_a++;
	end

	// ****************************
	// Tasks
	// ****************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
		input string msg);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic pulse(input logic [55:0] s, input logic [3:0] n);
		@(posedge clk);
		src <= s;
		nmi <= n;
		@(posedge clk);
		src <= '0;
		nmi <= '0;
	endtask

	// Samples settled values; one extra edge lets the last write-back land
	task automatic wait_idle;
		t = 0;
		while (busy !== 1'b1 && t < 20) begin
			@(posedge clk);
			#1;
			t++;
		end
		t = 0;
		while (busy === 1'b1 && t < 3000) begin
			@(posedge clk);
			#1;
			t++;
		end
		@(posedge clk);
		#1;
		chk(t < 3000, 1, "busy stuck");
	endtask

	task automatic clear_nmi;
		reg_rd(16'h0080, rv);
		reg_wr(16'h0080, 8'h00);
	endtask

	task automatic load_cd(input logic [4:0] s, input logic [63:0] v);
		for (int i = 0; i < 8; i++) begin
			u_mem.mem[16'h2C40 + 16'(s) * 8 + i] = v[8*i +: 8];
		end
	endtask

	function automatic logic [7:0] cdb(input int s, input int k);
		return u_mem.mem[16'h2C40 + s * 8 + k];
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	initial begin
		#(40 * 20000);
		miscompares++;
		$display("FAIL %0t watchdog expired", $time);
		tally_and_finish;
	end

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		clk = 0; reset_n = 0; addr = '0; wdata = '0; wr = 0; rd = 0;
		nmi = '0; src = '0; miscompares = 0; checks_done = 0;
		mem_reads = 0; clr_a = 0;
		osc_irq_en = 1'b1;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		#1 chk(busy, 1'b0, "reset busy");
		chk(ir_sup, '0, "reset suppress");
		chk(mem, '0, "reset memory port");
		chk(flag_clr, '0, "reset flag clear");
		chk(rdata, 8'h00, "reset read data");
		reg_rd(16'h0080, rv);
		chk(rv, 8'h00, "control reset value");
		foreach (rows[i]) begin
			reg_wr(rows[i].addr, rows[i].wdata);
			reg_rd(rows[i].addr, rv);
			chk(rv, rows[i].exp, "register row");
		end
		for (int i = 0; i < 7; i++) reg_wr(16'h0088 + 16'(i), 8'h00);
		$display("register table done");
		// Every event kind sets the flag; only read-one then write-zero clears
		for (int k = 0; k < 4; k++) begin
			pulse('0, 4'(1 << k));
			repeat (tac_pkg::WDT_WAIT_DIV16) @(posedge clk);
			// Oscillation-stop interrupt disabled before the flag clear
			if (k == 1) osc_irq_en = 1'b0;
			reg_rd(16'h0080, rv);
			chk(rv, 8'h02, "flag set by event");
			reg_wr(16'h0080, 8'h02);
			reg_wr(16'h0080, 8'h00);
			reg_rd(16'h0080, rv);
			chk(rv, 8'h02, "flag kept without prior read");
			reg_wr(16'h0080, 8'h00);
			reg_rd(16'h0080, rv);
			chk(rv, 8'h00, "flag cleared");
		end
		$display("flag test done");
		// Enabled request while flag set is dropped, not held
		reg_wr(16'h008A, 8'h02);
		pulse('0, 4'h4);
		n0 = mem_reads;
		pulse(56'(1) << 17, '0);
		wait_idle;
		clear_nmi;
		repeat (10) @(posedge clk);
		chk(mem_reads, n0, "activation refused");
		$display("refusal test done");
		// Normal mode, both addresses incrementing, two bytes per activation
		u_mem.mem[16'h2C11] = 8'h05;
		load_cd(5, 64'h2000_1000_00_02_02_0C);
		for (int i = 0; i < 4; i++) u_mem.mem[16'h1000 + i] = 8'(8'h11 * (i + 1));
		chk(ir_sup[17], 1'b1, "suppress while enabled");
		pulse(56'(1) << 17, '0);
		wait_idle;
		chk({u_mem.mem[16'h2001], u_mem.mem[16'h2000]}, 16'h2211, "block");
		chk(cdb(5, 2), 8'h01, "count written back");
		chk({cdb(5, 5), cdb(5, 4), cdb(5, 7), cdb(5, 6)}, 32'h10022002, "addr");
		chk(clr_a, 1, "match A flag cleared");
		reg_rd(16'h008A, rv);
		chk(rv, 8'h02, "enable kept");
		// Last count with an event arriving mid-transfer
		pulse(56'(1) << 17, '0);
		repeat (4) @(posedge clk);
		pulse('0, 4'h8);
		wait_idle;
		chk({u_mem.mem[16'h2003], u_mem.mem[16'h2002]}, 16'h4433, "not aborted");
		chk(cdb(5, 2), 8'h00, "count at zero");
		chk(clr_a, 1, "no flag clear at end");
		reg_rd(16'h008A, rv);
		chk(rv, 8'h00, "enable cleared");
		chk(ir_sup[17], 1'b0, "suppress follows enable");
		clear_nmi;
		$display("normal mode test done");
		// Two sources at once, repeat set chained to a normal set
		u_mem.mem[16'h2C08] = 8'h00;
		u_mem.mem[16'h2C09] = 8'h01;
		load_cd(0, 64'h2100_1100_03_01_01_12);
		load_cd(1, 64'h2101_1101_00_05_01_00);
		u_mem.mem[16'h1100] = 8'hAA;
		u_mem.mem[16'h1101] = 8'hBB;
		reg_wr(16'h0089, 8'h03);
		vecq.delete();
		pulse(56'h300, '0);
		wait_idle;
		wait_idle;
		chk(vecq.size(), 2, "both served");
		chk(vecq[0], 16'h2C08, "higher priority first");
		chk(vecq[1], 16'h2C09, "pending served next");
		chk(cdb(0, 2), 8'h03, "repeat reload");
		chk(cdb(1, 2), 8'h03, "chained set ran twice");
		chk({u_mem.mem[16'h2101], u_mem.mem[16'h2100]}, 16'hBBAA, "data");
		reg_rd(16'h0089, rv);
		chk(rv, 8'h03, "repeat keeps enable");
		$display("chain test done");
		tally_and_finish;
	end
endmodule // tac_top_tb
`default_nettype wire
